// ==== core/dead_time_timer.sv ====
// dead-time pwm timer: four-ramp and dual-slope waveforms, fault/capture inputs, command strobes
`timescale 1ns/10ps
module dead_time_timer
    import dtt_pkg::*;
#(
    parameter int CW = CNT_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // register port
    input  wire logic [AW-1:0]    addr,
    input  wire logic [DAT_W-1:0] wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    output logic      [DAT_W-1:0] rdata,
    // event inputs
    input  wire logic             event_a,
    input  wire logic             event_b,
    // waveform outputs
    output logic                  output_a,
    output logic                  output_b
);

    // software-side registers
    logic             en;
    logic             en_q;
    logic [1:0]       wg;
    logic [CMD_W-1:0] cmd_pend;
    logic             upd_req;
    logic             stop_req;
    evctl_t           evc [2];
    logic [FM_W-1:0]  fm [2];
    dlyctl_t          dly;
    logic [CW-1:0]    blank_len;
    logic [CW-1:0]    cas_w, cac_w, cbs_w, cbc_w;
    logic [CW-1:0]    cas, cac, cbs, cbc;
    logic [CW-1:0]    cap_a, cap_b;
    // core state
    logic [CW-1:0]    cnt;
    st_t              st;
    logic             dn;
    logic             wave_a, wave_b;
    logic             halt;
    logic             blank_act;
    logic [CW-1:0]    bcnt;
    logic [3:0]       presc;
    logic [DAT_W-1:0] rd_val;

    // address decode
    logic wr_ctrl, wr_cmd, cmd_rdy, dual, start, init, step, load_buf;
    assign wr_ctrl  = wr && (addr == A_CTRL);
    assign wr_cmd   = wr && (addr == A_CMD);
    assign cmd_rdy  = (cmd_pend == '0);
    assign dual     = (wg == WG_DUAL);
    assign start    = en && !en_q;
    assign init     = start || cmd_pend[C_RESTART];
    assign step     = en && en_q && !halt && !cmd_pend[C_RESTART];
    logic eoc;
    assign load_buf = start || cmd_pend[C_UPD_NOW] || (eoc && upd_req);

    // enable bit; mode bits are only writable while disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en   <= 1'b0;
            en_q <= 1'b0;
            wg   <= '0;
        end else begin
            en_q <= en;
            if (wr_ctrl && !en) begin
                wg <= wdata[WG_LSB +: 2];
            end
            if (wr_ctrl) begin
                en <= wdata[EN_BIT];
            end else if (eoc && stop_req) begin
                en <= 1'b0;
            end
        end
    end

    // command strobes live one cycle, then clear; cycle-end requests wait for eoc
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_pend <= '0;
            upd_req  <= 1'b0;
            stop_req <= 1'b0;
        end else begin
            cmd_pend <= (wr_cmd && en && cmd_rdy) ? wdata[CMD_W-1:0] : '0;
            if (!en || eoc) begin
                upd_req  <= 1'b0;
                stop_req <= 1'b0;
            end
            if (cmd_pend[C_UPD_EOC] && en) begin
                upd_req <= 1'b1;
            end
            if (cmd_pend[C_STOP_EOC] && en) begin
                stop_req <= 1'b1;
            end
        end
    end

    // static and buffered configuration writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evc       <= '{default: '0};
            fm        <= '{default: '0};
            dly       <= '0;
            blank_len <= '0;
            cas_w     <= '0;
            cac_w     <= '0;
            cbs_w     <= '0;
            cbc_w     <= '0;
        end else if (wr) begin
            unique case (addr)
                A_EVA:   evc[0]    <= evctl_t'(wdata[EVC_W-1:0]);
                A_EVB:   evc[1]    <= evctl_t'(wdata[EVC_W-1:0]);
                A_FLTA:  fm[0]     <= wdata[FM_W-1:0];
                A_FLTB:  fm[1]     <= wdata[FM_W-1:0];
                A_DLYC:  dly       <= dlyctl_t'(wdata[DLC_W-1:0]);
                A_DLYV:  blank_len <= wdata[CW-1:0];
                A_CAS:   cas_w     <= wdata[CW-1:0];
                A_CAC:   cac_w     <= wdata[CW-1:0];
                A_CBS:   cbs_w     <= wdata[CW-1:0];
                A_CBC:   cbc_w     <= wdata[CW-1:0];
                default: ;
            endcase
        end
    end

    // compare values seen by the core change only on start or update commands
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cas <= '0;
            cac <= '0;
            cbs <= '0;
            cbc <= '0;
        end else if (load_buf) begin
            cas <= cas_w;
            cac <= cac_w;
            cbs <= cbs_w;
            cbc <= cbc_w;
        end
    end

    // counter next state; the a-clear compare only feeds the four-ramp limit
    logic [CW-1:0] lim, next_cnt;
    st_t           next_st;
    logic          next_dn, next_wa, next_wb, hit;
    assign lim = (st == ST_DTA) ? cas : (st == ST_OTA) ? cac : (st == ST_DTB) ? cbs : cbc;
    assign hit = (cnt == lim);
    assign eoc = step && (dual ? (!dn && cnt >= cbc) : (st == ST_OTB && hit));
    always_comb begin
        next_cnt = cnt;
        next_st  = st;
        next_dn  = dn;
        next_wa  = wave_a;
        next_wb  = wave_b;
        if (dual) begin
            if (dn) begin
                next_cnt = (cnt == '0) ? cnt : cnt - 1'b1;
                next_dn  = (cnt != '0);
                if (cnt == cas) next_wa = 1'b1;
                if (cnt == cbs) next_wb = 1'b0;
            end else begin
                next_cnt = (cnt >= cbc) ? cnt : cnt + 1'b1;
                next_dn  = (cnt >= cbc);
                if (cnt == cas) next_wa = 1'b0;
                if (cnt == cbs) next_wb = 1'b1;
            end
        end else begin
            // each phase ends on its own compare, so any ordering works
            if (hit) begin
                next_cnt = '0;
                next_st  = st_t'(st + 1'b1);
            end else begin
                next_cnt = cnt + 1'b1;
            end
            next_wa = (next_st == ST_OTA);
            next_wb = (next_st == ST_OTB);
        end
    end

    // counter and raw waveform registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt    <= '0;
            st     <= ST_DTA;
            dn     <= 1'b1;
            wave_a <= 1'b0;
            wave_b <= 1'b0;
        end else if (!en || init) begin
            cnt    <= (dual && en) ? cbc_w : '0;
            st     <= ST_DTA;
            dn     <= 1'b1;
            wave_a <= 1'b0;
            wave_b <= 1'b0;
        end else if (step) begin
            cnt    <= next_cnt;
            st     <= next_st;
            dn     <= next_dn;
            wave_a <= next_wa;
            wave_b <= next_wb;
        end
    end

    // input processing, one lane per event input
    logic [1:0] ev_in, kill, halt_set, cap_trig, proc;
    assign ev_in = {event_b, event_a};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_in
            logic [FILT_LEN-2:0] hist;
            logic raw, filt, s1, s2, proc_q, mask, asyn, fault_on, all_one, all_zero;
            assign raw      = ev_in[gi] && evc[gi].trig_en;
            assign all_one  = &{hist, raw};
            assign all_zero = ~|{hist, raw};
            assign mask     = (gi == 0) && blank_act;
            assign proc[gi] = s2 && !mask;
            // async path skips the synchroniser but still ends in the output flop
            assign asyn     = raw && evc[gi].async_det && !mask;
            assign fault_on = !evc[gi].action && fm[gi] != FM_OFF && fm[gi] <= FM_LAST;
            assign kill[gi]     = fault_on && fm[gi] != FM_HALT && (proc[gi] || asyn);
            assign halt_set[gi] = fault_on && fm[gi] == FM_HALT && proc[gi];
            assign cap_trig[gi] = evc[gi].action && proc[gi] && !proc_q;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    hist   <= '0;
                    filt   <= 1'b0;
                    s1     <= 1'b0;
                    s2     <= 1'b0;
                    proc_q <= 1'b0;
                end else begin
                    hist   <= {hist[FILT_LEN-3:0], raw};
                    if (all_one) filt <= 1'b1;
                    else if (all_zero) filt <= 1'b0;
                    s1     <= evc[gi].filter ? filt : raw;
                    s2     <= s1;
                    proc_q <= proc[gi];
                end
            end
            // the filtered level may only move after four equal samples in a row
            property p_filter;
                @(posedge clk) disable iff (!rst_n)
                evc[gi].filter && $changed(filt) |-> $past(all_one) || $past(all_zero);
            endproperty
            a_filter: assert property (p_filter) else $error("filter passed a short pulse");
        end
    endgenerate

    // halt waits for a restart or a disable; a still-active event halts again at once on restart
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt <= 1'b0;
        end else begin
            if (!en || cmd_pend[C_RESTART]) halt <= 1'b0;
            if (en && |halt_set) halt <= 1'b1;
        end
    end

    // blanking delay; output-event use of this circuit is not offered, so only one user
    logic trg, tick;
    logic [3:0] pmax;
    assign pmax = 4'((4'h1 << dly.divider) - 4'h1);
    assign tick = (presc == pmax);
    always_comb begin
        unique case (dly.trig_src)
            TRG_A_RISE: trg = next_wa && !wave_a;
            TRG_A_FALL: trg = !next_wa && wave_a;
            TRG_B_RISE: trg = next_wb && !wave_b;
            default:    trg = !next_wb && wave_b;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blank_act <= 1'b0;
            bcnt      <= '0;
            presc     <= '0;
        end else if (dly.sel == BLANK_ON && step && trg) begin
            blank_act <= 1'b1;
            bcnt      <= '0;
            presc     <= '0;
        end else if (blank_act) begin
            presc <= tick ? '0 : presc + 1'b1;
            if (tick) bcnt <= bcnt + 1'b1;
            if (bcnt >= blank_len) blank_act <= 1'b0;
        end
    end

    // captures take the running counter value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_a <= '0;
            cap_b <= '0;
        end else begin
            if (cmd_pend[C_CAP_A] || cap_trig[0]) cap_a <= cnt;
            if (cmd_pend[C_CAP_B] || cap_trig[1]) cap_b <= cnt;
        end
    end

    // final outputs: kill acts on the output flop only; halt also stops the counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_a <= 1'b0;
            output_b <= 1'b0;
        end else begin
            output_a <= en && wave_a && !halt && !(|kill);
            output_b <= en && wave_b && !halt && !(|kill);
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        rd_val = '0;
        unique case (addr)
            A_CTRL: rd_val = DAT_W'({wg, en});
            A_STAT: rd_val = DAT_W'({cmd_rdy, en});
            A_EVA:  rd_val = DAT_W'(evc[0]);
            A_EVB:  rd_val = DAT_W'(evc[1]);
            A_FLTA: rd_val = DAT_W'(fm[0]);
            A_FLTB: rd_val = DAT_W'(fm[1]);
            A_DLYC: rd_val = DAT_W'(dly);
            A_DLYV: rd_val = DAT_W'(blank_len);
            A_CAS:  rd_val = DAT_W'(cas_w);
            A_CAC:  rd_val = DAT_W'(cac_w);
            A_CBS:  rd_val = DAT_W'(cbs_w);
            A_CBC:  rd_val = DAT_W'(cbc_w);
            A_CAPA: rd_val = DAT_W'(cap_a);
            A_CAPB: rd_val = DAT_W'(cap_b);
            default: rd_val = '0;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rdata <= '0;
        else        rdata <= rd ? rd_val : '0;
    end

    // checks
    property p_four_wrap;
        @(posedge clk) disable iff (!rst_n)
        !dual && step && st == ST_OTB && cnt == cbc |=> cnt == '0 && st == ST_DTA;
    endproperty
    a_four_wrap: assert property (p_four_wrap) else $error("four-ramp cycle did not wrap");
    property p_no_overlap;
        @(posedge clk) disable iff (!rst_n)
        !dual && en_q |-> !(output_a && output_b);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("four-ramp outputs overlap");
    property p_dual_turn;
        @(posedge clk) disable iff (!rst_n)
        dual && step && !dn && cnt == cbc |=> dn && cnt == $past(cnt);
    endproperty
    a_dual_turn: assert property (p_dual_turn) else $error("dual-slope did not turn at top");
    property p_dual_a_set;
        @(posedge clk) disable iff (!rst_n)
        dual && step && dn && cnt == cas |=> wave_a;
    endproperty
    a_dual_a_set: assert property (p_dual_a_set) else $error("output a not set on down match");
    property p_dual_b_set;
        @(posedge clk) disable iff (!rst_n)
        dual && step && !dn && cnt == cbs |=> wave_b ##1 (output_b || $past(halt) || $past(kill) != '0 || !$past(en));
    endproperty
    a_dual_b_set: assert property (p_dual_b_set) else $error("output b not set on up match");
    property p_stop_eoc;
        @(posedge clk) disable iff (!rst_n)
        eoc && stop_req && !wr_ctrl |=> !en ##1 (!output_a && !output_b);
    endproperty
    a_stop_eoc: assert property (p_stop_eoc) else $error("timer still running after cycle end");
    property p_disable;
        @(posedge clk) disable iff (!rst_n)
        wr_ctrl && !wdata[EN_BIT] |=> !en ##1 (!output_a && !output_b);
    endproperty
    a_disable: assert property (p_disable) else $error("enable write low did not stop timer");
    property p_kill;
        @(posedge clk) disable iff (!rst_n)
        kill != '0 |=> !output_a && !output_b;
    endproperty
    a_kill: assert property (p_kill) else $error("fault did not override outputs");
    property p_strobe_clear;
        @(posedge clk) disable iff (!rst_n)
        cmd_pend != '0 |=> cmd_pend == '0;
    endproperty
    a_strobe_clear: assert property (p_strobe_clear) else $error("command strobe did not clear");
    property p_blank_mask;
        @(posedge clk) disable iff (!rst_n)
        blank_act && g_in[0].s2 |-> kill[0] == 1'b0 && cap_trig[0] == 1'b0 && halt_set[0] == 1'b0;
    endproperty
    a_blank_mask: assert property (p_blank_mask) else $error("input a acted while blanked");

endmodule : dead_time_timer

// ==== core/dtt_pkg.sv ====
// register map, field layout, modes and carrier types of the dead-time timer
package dtt_pkg;
    localparam int CNT_W = 12;
    localparam int DAT_W = 16;
    localparam int AW    = 4;
    // register word addresses
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_CMD  = 4'h1;
    localparam logic [3:0] A_STAT = 4'h2;
    localparam logic [3:0] A_EVA  = 4'h3;
    localparam logic [3:0] A_EVB  = 4'h4;
    localparam logic [3:0] A_FLTA = 4'h5;
    localparam logic [3:0] A_FLTB = 4'h6;
    localparam logic [3:0] A_DLYC = 4'h7;
    localparam logic [3:0] A_DLYV = 4'h8;
    localparam logic [3:0] A_CAS  = 4'h9;
    localparam logic [3:0] A_CAC  = 4'ha;
    localparam logic [3:0] A_CBS  = 4'hb;
    localparam logic [3:0] A_CBC  = 4'hc;
    localparam logic [3:0] A_CAPA = 4'hd;
    localparam logic [3:0] A_CAPB = 4'he;
    // control_first_reg fields
    localparam int EN_BIT = 0;
    localparam int WG_LSB = 1;
    localparam logic [1:0] WG_DUAL = 2'h3;
    // command_strobe_reg bits
    localparam int CMD_W      = 8;
    localparam int C_UPD_EOC  = 0;
    localparam int C_UPD_NOW  = 1;
    localparam int C_RESTART  = 2;
    localparam int C_CAP_A    = 3;
    localparam int C_CAP_B    = 4;
    localparam int C_STOP_EOC = 7;
    // status bits
    localparam int S_EN  = 0;
    localparam int S_RDY = 1;
    // fault_response_select codes
    localparam int FM_W = 4;
    localparam logic [3:0] FM_OFF  = 4'h0;
    localparam logic [3:0] FM_HALT = 4'h7;
    localparam logic [3:0] FM_LAST = 4'ha;
    // filter length in counter clocks
    localparam int FILT_LEN = 4;
    // blanking_select and blanking_trigger_source codes
    localparam logic [1:0] BLANK_ON   = 2'h1;
    localparam logic [1:0] TRG_A_RISE = 2'h0;
    localparam logic [1:0] TRG_A_FALL = 2'h1;
    localparam logic [1:0] TRG_B_RISE = 2'h2;
    localparam int EVC_W = 4;
    localparam int DLC_W = 6;
    typedef struct packed {
        logic async_det;
        logic filter;
        logic action;
        logic trig_en;
    } evctl_t;
    typedef struct packed {
        logic [1:0] divider;
        logic [1:0] trig_src;
        logic [1:0] sel;
    } dlyctl_t;
    typedef enum logic [1:0] {ST_DTA, ST_OTA, ST_DTB, ST_OTB} st_t;
endpackage : dtt_pkg

// ==== testbench/event_source.sv ====
// model of the event routing that feeds the timer's two event inputs
`timescale 1ns/10ps
module event_source (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // requests from the bench
    input  wire logic req_a,
    input  wire logic req_b,
    // event lines toward the timer
    output logic      event_a,
    output logic      event_b
);
    // launched on the timer clock so events meet the synchronous path; async with filter is never asked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            event_a <= 1'b0;
            event_b <= 1'b0;
        end else begin
            event_a <= req_a;
            event_b <= req_b;
        end
    end
endmodule : event_source

// ==== testbench/tb.sv ====
// self-checking bench for the dead-time timer
`timescale 1ns/10ps
module tb;
    import dtt_pkg::*;
    logic             clk, rst_n, wr, rd, req_a, req_b, event_a, event_b, output_a, output_b;
    logic [AW-1:0]    addr;
    logic [DAT_W-1:0] wdata, rdata, v, gap, hi, both;
    int               n_errors, check_count;
    dead_time_timer i_dead_time_timer (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .event_a(event_a), .event_b(event_b), .output_a(output_a), .output_b(output_b));
    event_source i_event_source (.clk(clk), .rst_n(rst_n), .req_a(req_a), .req_b(req_b),
        .event_a(event_a), .event_b(event_b));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task chk(input string name, input logic [DAT_W-1:0] exp, input logic [DAT_W-1:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task wr_reg(input logic [AW-1:0] a, input logic [DAT_W-1:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stands only in the cycle after the strobe, so it is taken at that cycle's falling edge
    task rd_reg(input logic [AW-1:0] a, output logic [DAT_W-1:0] d);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg
    // cycles between two rises of one output, its high cycles and the overlap cycles in that span
    task rise_gap(input bit sel_b);
        logic prev, o;
        int   i, first;
        first = -1; gap = '0; hi = '0; both = '0; prev = 1'b1;
        for (i = 0; i < 300; i++) begin
            @(negedge clk);
            o = sel_b ? output_b : output_a;
            if (o === 1'b1 && prev === 1'b0 && first >= 0) begin
                gap = DAT_W'(i - first);
                break;
            end
            if (o === 1'b1 && prev === 1'b0) first = i;
            if (first >= 0 && o === 1'b1) hi++;
            if (first >= 0 && output_a === 1'b1 && output_b === 1'b1) both++;
            prev = o;
        end
    endtask : rise_gap
    // both outputs must stay low for a span longer than any period used here
    task quiet(input string name);
        int n;
        n = 0;
        repeat (30) begin
            @(negedge clk);
            if ((output_a | output_b) !== 1'b0) n++;
        end
        chk(name, '0, DAT_W'(n));
    endtask : quiet
    task t_reset;
        rd_reg(A_CTRL, v); chk("ctrl reset", '0, v);
        rd_reg(A_CAPA, v); chk("capture a reset", '0, v);
        rd_reg(4'hf, v); chk("unmapped read", '0, v);
    endtask : t_reset
    // unordered compares 3,1,4,2: period is the sum plus four
    task t_four_ramp;
        wr_reg(A_CAS, 16'h0003); wr_reg(A_CAC, 16'h0001); wr_reg(A_CBS, 16'h0004); wr_reg(A_CBC, 16'h0002);
        wr_reg(A_CTRL, 16'h0001);
        rd_reg(A_STAT, v); chk("status enabled", 16'h0003, v);
        rise_gap(1'b0); chk("four ramp period", 16'd14, gap);
        chk("on time a", 16'd2, hi);
        chk("overlap four ramp", '0, both);
        rise_gap(1'b1); chk("on time b", 16'd3, hi);
    endtask : t_four_ramp
    task t_fault_a;
        wr_reg(A_CTRL, 16'h0000);
        rd_reg(A_STAT, v); chk("disabled at once", 1'b0, v[S_EN]);
        wr_reg(A_EVA, 16'h0001); wr_reg(A_FLTA, 16'h0004); wr_reg(A_CTRL, 16'h0001);
        req_a <= 1'b1;
        repeat (4) @(negedge clk);
        quiet("fault mode 4 outputs");
        wr_reg(A_CTRL, 16'h0000); wr_reg(A_FLTA, {12'h000, FM_OFF}); wr_reg(A_CTRL, 16'h0001);
        rise_gap(1'b0); chk("mode 0 leaves outputs", 16'd14, gap);
        req_a <= 1'b0;
        // a three-cycle pulse just before on time b must not shorten it once filtered
        wr_reg(A_CTRL, 16'h0000); wr_reg(A_EVA, 16'h0005); wr_reg(A_FLTA, 16'h0004); wr_reg(A_CTRL, 16'h0001);
        rise_gap(1'b0);
        @(posedge clk);
        req_a <= 1'b1;
        repeat (3) @(posedge clk);
        req_a <= 1'b0;
        rise_gap(1'b1); chk("filtered pulse on time b", 16'd3, hi);
    endtask : t_fault_a
    // dual slope with a-set above b-set overlaps; a-clear of 9 must not matter
    task t_dual;
        wr_reg(A_CTRL, 16'h0000);
        wr_reg(A_CAS, 16'h0003); wr_reg(A_CAC, 16'h0009); wr_reg(A_CBS, 16'h0002); wr_reg(A_CBC, 16'h0005);
        wr_reg(A_EVB, 16'h0001); wr_reg(A_FLTB, {12'h000, FM_HALT}); // mode 7 is valid in dual slope
        wr_reg(A_CTRL, {13'h0000, WG_DUAL, 1'b1});
        rise_gap(1'b0); chk("dual period", 16'd12, gap);
        chk("dual overlap", 1'b1, both != '0);
        rise_gap(1'b1); chk("dual period b", 16'd12, gap);
    endtask : t_dual
    task t_halt_b;
        req_b <= 1'b1;
        repeat (2) @(posedge clk);
        req_b <= 1'b0;
        repeat (4) @(negedge clk);
        quiet("halt holds after release");
        rd_reg(A_STAT, v); chk("command ready", 1'b1, v[S_RDY]);
        wr_reg(A_CMD, 16'h0001 << C_RESTART);
        // restart reloads b-clear (5); the capture strobe lands one count later
        wr_reg(A_CMD, 16'h0001 << C_CAP_A);
        rd_reg(A_CAPA, v); chk("soft capture a", 16'd4, v);
        rise_gap(1'b0); chk("restart period", 16'd12, gap);
        wr_reg(A_CBC, 16'h0006); wr_reg(A_CMD, 16'h0001 << C_UPD_NOW);
        rise_gap(1'b0); chk("update now period", 16'd14, gap);
    endtask : t_halt_b
    task t_stop;
        wr_reg(A_CMD, 16'h0001 << C_STOP_EOC);
        repeat (14) @(negedge clk);
        quiet("stopped outputs");
        rd_reg(A_STAT, v); chk("stop at cycle end", 1'b0, v[S_EN]);
        // capture action on input a while stopped takes the idle counter, replacing the soft capture
        wr_reg(A_EVA, 16'h0003);
        @(posedge clk);
        req_a <= 1'b1;
        repeat (4) @(posedge clk);
        req_a <= 1'b0;
        rd_reg(A_CAPA, v); chk("event capture a", '0, v);
    endtask : t_stop
    task tally_and_finish;
        if (n_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        #(50 * 20000);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        n_errors = 0; check_count = 0;
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; req_a = 1'b0; req_b = 1'b0; addr = '0; wdata = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_four_ramp();
        t_fault_a();
        t_dual();
        t_halt_b();
        t_stop();
        tally_and_finish();
    end
endmodule : tb
